/* File: logic/dru_pkg.sv */
// constants, register map and carrier types for the dual half-duplex serial ports
// assumes a single 25 MHz system clock and a simple strobed register port
// Overview of operation
// - control bit 0 enables transmitter and receiver of a port together
// - writing a character while enabled starts transmission with no further command
// - control bit 1 adds parity on transmit and checks it on receive
// - control bit 2 picks odd parity when set, even when clear
// - control bit 3 picks two stop bits when set, one when clear
// - next start bit follows stop bits at once; else line idles marking
// - control bit 15 drives transceiver direction, one transmits, zero receives
// - direction comes up as receive after reset
// - bit rate is 18.432 MHz over sixteen times divisor in bits 12-4
// - one set of settings serves both transmitter and receiver of a port
// - receiver captures characters on its own while enabled
// - data port holds a character in bits 7-0; read after data-available
// - data port read returns last received character, never the transmitted one
// - sticky flags in status bits 8-11 and 12-15, cleared by writing one
// - framing error on bad stop bit, parity error on parity mismatch
package dru_pkg;
  localparam logic [7:0] OFS_STATUS = 8'he0;
  localparam logic [7:0] OFS_CTRL_A = 8'he4;
  localparam logic [7:0] OFS_CHAR_A = 8'he8;
  localparam logic [7:0] OFS_CTRL_B = 8'hec;
  localparam logic [7:0] OFS_CHAR_B = 8'hf0;
  localparam int STAT_POS_A = 8;
  localparam int STAT_POS_B = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h9fff;
  localparam int SYS_CLK_KHZ = 25000;
  localparam int REF_CLK_KHZ = 18432;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [7:0] LINE_MARK = 8'hff;

  typedef struct packed {
    logic dir;
    logic [1:0] spare;
    logic [8:0] div;
    logic stop2;
    logic odd;
    logic par_en;
    logic en;
  } dru_ctrl_t;

  typedef struct packed {
    logic par;
    logic frm;
    logic dav;
    logic done;
  } dru_flags_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } dru_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } dru_rx_state_t;
endpackage

/* File: logic/dru_top.sv */
// two serial ports with transmit fifos, register port and transceiver direction
// assumes the register strobes are synchronous to sys_clk; line pins are not
`timescale 1ns/1ns

module dru_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // refused at elaboration: the full flag needs at least two slots
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("fifo depth must be at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] wp_nx = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
  wire [AW-1:0] rp_nx = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
  assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_nx;
      if (pop) rp_q <= rp_nx;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

module dru_port #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // settings and host side
  input wire dru_pkg::dru_ctrl_t ctrl,
  input wire logic char_wr,
  input wire logic [7:0] char_wdata,
  output logic char_ready,
  output logic [7:0] rx_char,
  // one-cycle events
  output logic ev_done,
  output logic ev_dav,
  output logic ev_frm,
  output logic ev_par,
  // line, rx already synchronised
  input wire logic rx_line,
  output logic tx_line
);
  // baud generator: fractional accumulator makes the 18.432 MHz reference tick
  logic [14:0] acc_q;
  logic [8:0] dcnt_q;
  wire [15:0] acc_sum = {1'b0, acc_q} + 16'(dru_pkg::REF_CLK_KHZ);
  wire ref_tick = acc_sum >= 16'(dru_pkg::SYS_CLK_KHZ);
  wire [15:0] acc_nx = ref_tick ? acc_sum - 16'(dru_pkg::SYS_CLK_KHZ) : acc_sum;
  // divisor zero behaves as one, there is no faster setting to fall back on
  wire [8:0] div_last = (ctrl.div == '0) ? '0 : ctrl.div - 1'b1;
  wire os_tick = ref_tick && (dcnt_q >= div_last);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= '0;
      dcnt_q <= '0;
    end else if (!ctrl.en) begin
      acc_q <= '0;
      dcnt_q <= '0;
    end else begin
      acc_q <= acc_nx[14:0];
      if (ref_tick) dcnt_q <= os_tick ? '0 : dcnt_q + 1'b1;
    end
  end

  // transmit holding fifo
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  dru_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(char_wr && ctrl.en),
    .in_ready(char_ready),
    .in_data(char_wdata),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // transmitter
  dru_pkg::dru_tx_state_t tx_q, tx_d;
  logic [3:0] tos_q;
  logic [2:0] tbit_q;
  logic [7:0] tsh_q;
  logic tpar_q, tstop_q, tline_q;
  wire tbit_end = os_tick && (tos_q == dru_pkg::OS_LAST);
  wire t_last_stop = !ctrl.stop2 || tstop_q;
  wire t_frame_end = (tx_q == dru_pkg::TX_STOP) && tbit_end && t_last_stop;
  wire t_launch = ctrl.en && fifo_valid
    && ((tx_q == dru_pkg::TX_IDLE) || t_frame_end);
  assign fifo_pop = t_launch;
  wire t_par = ctrl.odd ? ~^fifo_data : ^fifo_data;

  always_comb begin
    tx_d = tx_q;
    case (tx_q)
      dru_pkg::TX_IDLE: if (t_launch) tx_d = dru_pkg::TX_START;
      dru_pkg::TX_START: if (tbit_end) tx_d = dru_pkg::TX_DATA;
      dru_pkg::TX_DATA: begin
        if (tbit_end && tbit_q == dru_pkg::DATA_LAST) begin
          tx_d = ctrl.par_en ? dru_pkg::TX_PAR : dru_pkg::TX_STOP;
        end
      end
      dru_pkg::TX_PAR: if (tbit_end) tx_d = dru_pkg::TX_STOP;
      dru_pkg::TX_STOP: begin
        if (t_frame_end) tx_d = t_launch ? dru_pkg::TX_START : dru_pkg::TX_IDLE;
      end
      default: tx_d = dru_pkg::TX_IDLE;
    endcase
    if (!ctrl.en) tx_d = dru_pkg::TX_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= dru_pkg::TX_IDLE;
      tos_q <= '0;
      tbit_q <= '0;
      tsh_q <= dru_pkg::LINE_MARK;
      tpar_q <= 1'b1;
      tstop_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      if (t_launch) begin
        tos_q <= '0;
        tbit_q <= '0;
        tsh_q <= fifo_data;
        tpar_q <= t_par;
        tstop_q <= 1'b0;
      end else if (os_tick) begin
        tos_q <= tos_q + 1'b1;
        if (tbit_end && tx_q == dru_pkg::TX_DATA) begin
          tbit_q <= tbit_q + 1'b1;
          tsh_q <= {1'b1, tsh_q[7:1]};
        end
        if (tbit_end && tx_q == dru_pkg::TX_STOP) tstop_q <= 1'b1;
      end
    end
  end

  // line level from flops; marking whenever idle or disabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tline_q <= 1'b1;
    end else begin
      case (tx_d)
        dru_pkg::TX_START: tline_q <= 1'b0;
        dru_pkg::TX_DATA: tline_q <= (tx_q == dru_pkg::TX_START) ? tsh_q[0]
          : (tbit_end ? tsh_q[1] : tsh_q[0]);
        dru_pkg::TX_PAR: tline_q <= tpar_q;
        default: tline_q <= 1'b1;
      endcase
    end
  end
  assign tx_line = tline_q;
  assign ev_done = t_frame_end;

  // receiver
  dru_pkg::dru_rx_state_t rx_q, rx_d;
  logic [3:0] ros_q;
  logic [2:0] rbit_q;
  logic [7:0] rsh_q, rchar_q;
  logic rpe_q;
  wire rbit_mid = os_tick && (ros_q == dru_pkg::OS_LAST);
  wire rstart_ok = os_tick && (ros_q == dru_pkg::OS_MID);
  wire r_exp_par = ctrl.odd ? ~^rsh_q : ^rsh_q;
  wire r_done = (rx_q == dru_pkg::RX_STOP) && rbit_mid;

  always_comb begin
    rx_d = rx_q;
    case (rx_q)
      dru_pkg::RX_IDLE: if (!rx_line) rx_d = dru_pkg::RX_START;
      dru_pkg::RX_START: begin
        if (rstart_ok) rx_d = rx_line ? dru_pkg::RX_IDLE : dru_pkg::RX_DATA;
      end
      dru_pkg::RX_DATA: begin
        if (rbit_mid && rbit_q == dru_pkg::DATA_LAST) begin
          rx_d = ctrl.par_en ? dru_pkg::RX_PAR : dru_pkg::RX_STOP;
        end
      end
      dru_pkg::RX_PAR: if (rbit_mid) rx_d = dru_pkg::RX_STOP;
      dru_pkg::RX_STOP: if (rbit_mid) rx_d = dru_pkg::RX_IDLE;
      default: rx_d = dru_pkg::RX_IDLE;
    endcase
    if (!ctrl.en) rx_d = dru_pkg::RX_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q <= dru_pkg::RX_IDLE;
      ros_q <= '0;
      rbit_q <= '0;
      rsh_q <= '0;
      rchar_q <= '0;
      rpe_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      if (rx_q == dru_pkg::RX_IDLE || (rx_q == dru_pkg::RX_START && rstart_ok)) begin
        // restart the count so later samples land mid-bit
        ros_q <= '0;
        rbit_q <= '0;
        rpe_q <= 1'b0;
      end else if (os_tick) begin
        ros_q <= ros_q + 1'b1;
      end
      if (rbit_mid && rx_q == dru_pkg::RX_DATA) begin
        rsh_q <= {rx_line, rsh_q[7:1]};
        rbit_q <= rbit_q + 1'b1;
      end
      if (rbit_mid && rx_q == dru_pkg::RX_PAR) rpe_q <= (rx_line != r_exp_par);
      if (r_done) rchar_q <= rsh_q;
    end
  end
  assign rx_char = rchar_q;
  assign ev_dav = r_done;
  assign ev_frm = r_done && !rx_line;
  assign ev_par = r_done && ctrl.par_en && rpe_q;
endmodule

module dru_top #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // transmit fifo room, index 0 is port a
  output logic [1:0] tx_fifo_ready,
  // serial lines and transceiver direction
  input wire logic [1:0] ser_rx,
  output logic [1:0] ser_tx,
  output logic [1:0] ser_dir
);
  dru_pkg::dru_ctrl_t ctrl_q [2];
  dru_pkg::dru_flags_t flags_q [2];
  logic [1:0] rx_s1_q, rx_s2_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic [7:0] rx_char [2];
  logic [1:0] ev_done, ev_dav, ev_frm, ev_par;

  wire sel_stat = reg_addr == dru_pkg::OFS_STATUS;
  wire [1:0] sel_ctrl = {reg_addr == dru_pkg::OFS_CTRL_B, reg_addr == dru_pkg::OFS_CTRL_A};
  wire [1:0] sel_char = {reg_addr == dru_pkg::OFS_CHAR_B, reg_addr == dru_pkg::OFS_CHAR_A};
  wire [3:0] clr_a = (reg_wr && sel_stat) ? reg_wdata[dru_pkg::STAT_POS_A +: 4] : 4'h0;
  wire [3:0] clr_b = (reg_wr && sel_stat) ? reg_wdata[dru_pkg::STAT_POS_B +: 4] : 4'h0;
  wire [3:0] clr [2] = '{clr_a, clr_b};
  wire [15:0] ctrl_wr = reg_wdata[15:0] & dru_pkg::CTRL_MASK;

  // rx pins cross into sys_clk through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_q <= 2'h3;
      rx_s2_q <= 2'h3;
    end else begin
      rx_s1_q <= ser_rx;
      rx_s2_q <= rx_s1_q;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    wire dru_pkg::dru_flags_t ev = '{par: ev_par[p], frm: ev_frm[p], dav: ev_dav[p],
      done: ev_done[p]};
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ctrl_q[p] <= dru_pkg::CTRL_RESET;
        flags_q[p] <= '0;
      end else begin
        if (reg_wr && sel_ctrl[p]) ctrl_q[p] <= ctrl_wr;
        flags_q[p] <= (flags_q[p] & ~clr[p]) | ev;
      end
    end
    dru_port #(.FIFO_DEPTH(FIFO_DEPTH)) u_port (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ctrl(ctrl_q[p]),
      .char_wr(reg_wr && sel_char[p]),
      .char_wdata(reg_wdata[7:0]),
      .char_ready(tx_fifo_ready[p]),
      .rx_char(rx_char[p]),
      .ev_done(ev_done[p]),
      .ev_dav(ev_dav[p]),
      .ev_frm(ev_frm[p]),
      .ev_par(ev_par[p]),
      .rx_line(rx_s2_q[p]),
      .tx_line(ser_tx[p])
    );
    assign ser_dir[p] = ctrl_q[p].dir;
  end

  // read mux; unmapped offsets read zero
  wire [31:0] stat_word = {16'h0, flags_q[1], flags_q[0], 8'h0};
  wire [31:0] rd_mux = sel_stat ? stat_word
    : sel_ctrl[0] ? {16'h0, ctrl_q[0]}
    : sel_ctrl[1] ? {16'h0, ctrl_q[1]}
    : sel_char[0] ? {24'h0, rx_char[0]}
    : sel_char[1] ? {24'h0, rx_char[1]}
    : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
endmodule

/* File: tb/dru_props.sv */
// checker for the dual serial port register port and port a line
// sees only dru_top ports; bound in at the foot of this file
`timescale 1ns/1ns
module dru_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // fifo room and lines
  input wire logic [1:0] tx_fifo_ready,
  input wire logic [1:0] ser_rx,
  input wire logic [1:0] ser_tx,
  input wire logic [1:0] ser_dir
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] ctl_a_q;
  wire wr_a = reg_wr && reg_addr == dru_pkg::OFS_CTRL_A;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_a_q <= 16'h0000;
    end else if (wr_a) begin
      ctl_a_q <= reg_wdata[15:0] & dru_pkg::CTRL_MASK;
    end
  end
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  AST_DIR_SET: assert property (wr_a |=> ser_dir[0] == $past(reg_wdata[15]))
    else $error("direction not taken from control");
  AST_DIR_HOLD: assert property (!wr_a |=> $stable(ser_dir[0]))
    else $error("direction moved without write");
  AST_CTRL_RD: assert property (s_rd(dru_pkg::OFS_CTRL_A) |=> reg_rdata == {16'h0000, $past(ctl_a_q)})
    else $error("control readback wrong");
  AST_CHAR_RD: assert property (s_rd(dru_pkg::OFS_CHAR_A) |=> reg_rdata[31:8] == 24'h000000)
    else $error("char upper bits set");
  AST_STAT_RD: assert property (s_rd(dru_pkg::OFS_STATUS) |=> reg_rdata[7:0] == 8'h00 && reg_rdata[31:16] == 16'h0000)
    else $error("status spare bits set");
  AST_IDLE_OFF: assert property (!ctl_a_q[0] [*3] |-> ser_tx[0])
    else $error("line active while disabled");
  AST_BIT_LEN: assert property ($fell(ser_tx[0]) |=> !ser_tx[0] [*8])
    else $error("low bit too short");
endmodule
bind dru_top dru_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .tx_fifo_ready(tx_fifo_ready), .ser_rx(ser_rx),
  .ser_tx(ser_tx), .ser_dir(ser_dir));

/* File: tb/dru_line_model.sv */
// remote serial device behind an rs-485 transceiver, one per port
// assumes bits of BITC system clocks, close to the divisor-one rate
`timescale 1ns/1ns
module dru_line_model #(
  parameter int BITC = 22
) (
  // clock
  input wire logic sys_clk,
  // block side
  input wire logic tx_pin,
  input wire logic dir,
  output logic rx_pin
);
  logic drv = 1'b1;
  // transceiver echoes our own driver while turned to transmit
  assign rx_pin = dir ? tx_pin : drv;
  task automatic send(input logic [11:0] f, input int n);
    @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      drv <= f[i];
      repeat (BITC) @(posedge sys_clk);
    end
    // biased bus idles marking
    drv <= 1'b1;
  endtask
  // samples n bits at mid-bit; g counts idle cycles before the start bit
  task automatic catch(input int n, output logic [11:0] f, output int g);
    g = 0;
    f = 12'hfff;
    while (tx_pin === 1'b1 && g < 2000) begin
      @(posedge sys_clk);
      g++;
    end
    if (g < 2000) begin
      repeat (BITC / 2) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
        f[i] = tx_pin;
        if (i < n - 1) repeat (BITC) @(posedge sys_clk);
      end
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the dual serial port block
// port a transmits to a line model, port b receives from one
`timescale 1ns/1ns
module tb_top;
  localparam int DEPTH = 4;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, v;
  logic reg_rvalid;
  logic [1:0] tx_fifo_ready, ser_tx, ser_dir;
  wire [1:0] ser_rx;
  logic [11:0] f;
  logic [3:0] modes [5] = '{4'h1, 4'h3, 4'h7, 4'h9, 4'hf};
  logic [7:0] dat [5] = '{8'h96, 8'h01, 8'hc3, 8'h7e, 8'h58};
  logic [31:0] errs [3] = '{32'h2000, 32'ha000, 32'h6000};
  int num_errors = 0;
  int n_compared = 0;
  int g, k;
  always #20 sys_clk = ~sys_clk;
  dru_top #(.FIFO_DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .tx_fifo_ready(tx_fifo_ready), .ser_rx(ser_rx),
    .ser_tx(ser_tx), .ser_dir(ser_dir));
  dru_line_model m_a (.sys_clk(sys_clk), .tx_pin(ser_tx[0]), .dir(ser_dir[0]), .rx_pin(ser_rx[0]));
  dru_line_model m_b (.sys_clk(sys_clk), .tx_pin(ser_tx[1]), .dir(ser_dir[1]), .rx_pin(ser_rx[1]));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", {31'h0, reg_rvalid}, 32'h1);
    d = reg_rdata;
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(dru_pkg::OFS_STATUS, v);
      if (v[b] === 1'b1) return;
    end
    chk("flag wait", 32'h0, 32'h1);
  endtask
  // m is {stop2, odd, par_en, en}; divisor one
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic dir);
    return {16'h0000, dir, 2'b00, 9'h001, m};
  endfunction
  function automatic logic [11:0] frm(input logic [7:0] d, input logic [3:0] m);
    if (m[1]) return {2'b11, ^d ^ m[2], d, 1'b0};
    return {3'b111, d, 1'b0};
  endfunction
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    // about 25000 cycles, two and a half times the longest path through the tests
    #1000000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk("dir after reset", {30'h0, ser_dir}, 32'h0);
    chk("idle lines", {30'h0, ser_tx}, 32'h3);
    chk("fifo room after reset", {30'h0, tx_fifo_ready}, 32'h3);
    rd(dru_pkg::OFS_CTRL_A, v);
    chk("ctrl a reset", v, 32'h0);
    rd(8'hf8, v);
    chk("unmapped", v, 32'h0);
    wr(dru_pkg::OFS_CTRL_B, 32'hffffffff);
    rd(dru_pkg::OFS_CTRL_B, v);
    chk("ctrl b mask", v, {16'h0, dru_pkg::CTRL_MASK});
    chk("dir b", {30'h0, ser_dir}, 32'h2);
    for (k = 0; k < 5; k++) begin
      wr(dru_pkg::OFS_CTRL_A, ctl(modes[k], 1'b1));
      fork
        wr(dru_pkg::OFS_CHAR_A, {24'h0, dat[k]});
        m_a.catch(10 + modes[k][1] + modes[k][3], f, g);
      join
      chk("tx frame", {20'h0, f}, {20'h0, frm(dat[k], modes[k])});
      // only the done bit is looked at: the echo makes receive flags meaningless here
      wait_flag(8);
      wr(dru_pkg::OFS_STATUS, 32'h100);
      rd(dru_pkg::OFS_STATUS, v);
      chk("done cleared", v & 32'h100, 32'h0);
    end
    // back to plain frames, the loop left parity and two stop bits behind
    wr(dru_pkg::OFS_CTRL_A, ctl(4'h1, 1'b1));
    fork
      begin
        wr(dru_pkg::OFS_CHAR_A, 32'h3c);
        wr(dru_pkg::OFS_CHAR_A, 32'ha5);
      end
      begin
        m_a.catch(10, f, g);
        m_a.catch(10, f, g);
      end
    join
    chk("next start gap", {31'h0, g <= 15}, 32'h1);
    chk("second frame", {20'h0, f}, {20'h0, frm(8'ha5, 4'h1)});
    m_a.catch(10, f, g);
    chk("idle marking", {31'h0, g >= 2000}, 32'h1);
    fork
      begin
        for (int i = 0; i <= DEPTH; i++) wr(dru_pkg::OFS_CHAR_A, {24'h0, dat[i]});
        // let the count settle past the edge that took the last write
        #1;
        chk("fifo full", {31'h0, tx_fifo_ready[0]}, 32'h0);
        wr(dru_pkg::OFS_CHAR_A, 32'h11);
      end
      begin
        k = 0;
        g = 0;
        while (g < 2000) begin
          m_a.catch(10, f, g);
          if (g < 2000) k++;
        end
      end
    join
    chk("frames drained", k, DEPTH + 1);
    chk("fifo room", {31'h0, tx_fifo_ready[0]}, 32'h1);
    wr(dru_pkg::OFS_CTRL_A, ctl(4'h0, 1'b1));
    fork
      wr(dru_pkg::OFS_CHAR_A, 32'h55);
      m_a.catch(10, f, g);
    join
    chk("disabled tx", {31'h0, g >= 2000}, 32'h1);
    rd(dru_pkg::OFS_CHAR_A, v);
    // port a heard its own frames through the echo; the dropped writes must not show
    chk("rx char a", v, {24'h0, dat[4]});
    wr(dru_pkg::OFS_CTRL_B, ctl(4'h7, 1'b0));
    for (k = 0; k < 3; k++) begin
      wr(dru_pkg::OFS_STATUS, 32'hf000);
      f = frm(dat[k], 4'h7);
      if (k == 1) f[9] = ~f[9];
      if (k == 2) f[10] = 1'b0;
      m_b.send(f, 11);
      wait_flag(13);
      rd(dru_pkg::OFS_CHAR_B, v);
      chk("rx char", v, {24'h0, dat[k]});
      rd(dru_pkg::OFS_STATUS, v);
      chk("rx flags", v & 32'hf000, errs[k]);
    end
    wr(dru_pkg::OFS_STATUS, 32'hf000);
    rd(dru_pkg::OFS_STATUS, v);
    chk("rx flags cleared", v & 32'hf000, 32'h0);
    wr(dru_pkg::OFS_CHAR_B, 32'ha5);
    rd(dru_pkg::OFS_CHAR_B, v);
    chk("no loop-back", v, {24'h0, dat[2]});
    m_b.catch(11, f, g);
    chk("b tx frame", {20'h0, f}, {20'h0, frm(8'ha5, 4'h7)});
    complete_run();
  end
endmodule
